// ### design/pswc_pkg.sv
// Purpose: Shared constants and types for the power state and wake controller.
// Assumes: 200 MHz core clock.
// Notes: Long delays are also top-level parameters so a simulation can shorten them.
package pswc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned RESUME_TIME_MS = 2;
	localparam int unsigned EVENT_PULSE_TIME_MS = 50;
	// Cycles per millisecond are taken first so the product stays inside 32 bits.
	localparam int unsigned CYCLES_PER_MS = 1000000000 / CLK_PERIOD_PS;
	localparam int unsigned RESUME_CYCLES = RESUME_TIME_MS * CYCLES_PER_MS;
	localparam int unsigned EVENT_PULSE_CYCLES = EVENT_PULSE_TIME_MS * CYCLES_PER_MS;
	localparam int unsigned RESUME_CNT_W = 19;
	localparam int unsigned PULSE_CNT_W = 24;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_WAKE_FRAME = 2'h1;
	localparam logic [1:0] MODE_ENERGY = 2'h2;
	localparam logic [1:0] WAKEUP_STATUS_FIELD_NONE = 2'h0;
	localparam logic [1:0] WAKEUP_STATUS_FIELD_ENERGY = 2'h1;
	localparam logic [1:0] WAKEUP_STATUS_FIELD_FRAME = 2'h2;

	localparam logic RESET_READY = 1'b1;
	localparam logic RESET_ARMED = 1'b0;
	localparam logic RESET_ENABLE = 1'b0;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_SLEEP_FRAME = 4'h2,
		ST_SLEEP_ENERGY = 4'h4,
		ST_RESUME = 4'h8
	} pswc_state_t;

	typedef struct packed {
		pswc_state_t state;
		logic ready;
		logic writesArmed;
		logic [1:0] powerMode;
		logic [1:0] wakeupStatus;
		logic wakeFrameEnable;
		logic energyDetectEnable;
		logic eventPinEnable;
		logic eventPinPulseMode;
		logic pmeIntStatus;
		logic eventPin;
		logic eventQualPrev;
		logic [PULSE_CNT_W-1:0] pulseCnt;
		logic [RESUME_CNT_W-1:0] resumeCnt;
		logic frameDetectOn;
		logic macHostClkEn;
		logic internalClkEn;
		logic rxPmClkEn;
		logic phyFullOn;
	} pswc_regs_t;
endpackage : pswc_pkg

// ### design/pswc_power_state_wake_ctrl.sv
// Purpose: Normal and two sleep states, wake detection, event pin and interrupt flag.
// Assumes: Host accesses arrive as one-cycle strobes synchronous to clk.
// Notes: The wake-frame filter and the PHY itself live outside this block.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Writing 01 to the power mode field enters the wake-frame sleep state.
// - Ready clears on entering either sleep state and stays clear until normal again.
// - Any write to the wake test register while asleep wakes and resets the mode field.
// - After reset or wake, writes are ignored until at least one read is seen.
// - Wake-frame sleep enables frame detection; pin needs frame and pin enables.
// - A frame detected in wake-frame sleep sets wake-up status to 10.
// - Carrier in energy sleep sets status 01; pin needs energy and pin enables.
// - The interrupt flag is set on any wake event regardless of the pin enable.
// - The flag holds while the event is active, then clears by writing one.
// - With pulse mode set, the event pin is active for 50 ms after an event.
// - With pulse mode clear, the event pin stays active until deactivated.
// - Clearing status, the matching wake enable or the pin enable drops the pin.
// - Carrier already present on entering energy sleep is detected at once.
// - Wake-frame sleep stops MAC and host; energy sleep stops all but detection.
// - Configuration and register contents are kept across both sleep states.
// - Ready is set within 2 ms of the waking write to the test register.
module pswc_power_state_wake_ctrl #(
	parameter int unsigned RESUME_CYCLES = pswc_pkg::RESUME_CYCLES,
	parameter int unsigned EVENT_PULSE_CYCLES = pswc_pkg::EVENT_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hostRead,
	input wire logic ctrlWrite,
	input wire logic [1:0] ctrlWrPowerMode,
	input wire logic ctrlWrWakeFrameEnable,
	input wire logic ctrlWrEnergyDetectEnable,
	input wire logic ctrlWrEventPinEnable,
	input wire logic ctrlWrEventPinPulseMode,
	input wire logic [1:0] ctrlWrWakeupStatusClear,
	input wire logic intStatusClearWrite,
	input wire logic testRegWrite,
	input wire logic wakeFrameDetected,
	input wire logic carrierPresent,
	output logic ready,
	output logic writesArmed,
	output logic [1:0] powerMode,
	output logic [1:0] wakeupStatus,
	output logic wakeFrameEnable,
	output logic energyDetectEnable,
	output logic eventPinEnable,
	output logic eventPinPulseMode,
	output logic pmeIntStatus,
	output logic eventPin,
	output logic frameDetectOn,
	output logic macHostClkEn,
	output logic internalClkEn,
	output logic rxPmClkEn,
	output logic phyFullOn
);
	import pswc_pkg::*;

	localparam logic [RESUME_CNT_W-1:0] RESUME_LOAD = RESUME_CNT_W'(RESUME_CYCLES - 1);
	localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(EVENT_PULSE_CYCLES);

	pswc_regs_t r_q;
	pswc_regs_t r_d;
	logic writeOk;
	logic eventActive;
	logic eventQual;
	pswc_state_t nextState;

	always_comb
	begin
		r_d = r_q;
		// Writes are honoured only once a read has been seen.
		writeOk = ctrlWrite && r_q.writesArmed && r_q.ready;
		nextState = r_q.state;

		if (hostRead)
		begin
			r_d.writesArmed = 1'b1;
		end

		case (r_q.state)
			ST_NORMAL:
			begin
				if (writeOk && ctrlWrPowerMode == MODE_WAKE_FRAME)
				begin
					nextState = ST_SLEEP_FRAME;
				end
				else if (writeOk && ctrlWrPowerMode == MODE_ENERGY)
				begin
					nextState = ST_SLEEP_ENERGY;
				end
				else
				begin
					nextState = ST_NORMAL;
				end
			end
			ST_SLEEP_FRAME, ST_SLEEP_ENERGY:
			begin
				if (testRegWrite)
				begin
					nextState = ST_RESUME;
				end
			end
			ST_RESUME:
			begin
				if (r_q.resumeCnt == '0)
				begin
					nextState = ST_NORMAL;
				end
			end
			default:
			begin
				nextState = ST_NORMAL;
			end
		endcase
		r_d.state = nextState;

		// Control fields change only by an honoured write, so sleep keeps them.
		if (writeOk)
		begin
			r_d.wakeFrameEnable = ctrlWrWakeFrameEnable;
			r_d.energyDetectEnable = ctrlWrEnergyDetectEnable;
			r_d.eventPinEnable = ctrlWrEventPinEnable;
			r_d.eventPinPulseMode = ctrlWrEventPinPulseMode;
			r_d.wakeupStatus = r_q.wakeupStatus & ~ctrlWrWakeupStatusClear;
		end

		// Detection is applied after the clear so a same-cycle event wins.
		if (r_q.state == ST_SLEEP_FRAME && wakeFrameDetected)
		begin
			r_d.wakeupStatus = WAKEUP_STATUS_FIELD_FRAME;
		end
		// A carrier level already present is seen on the first sleep cycle.
		if (r_q.state == ST_SLEEP_ENERGY && carrierPresent)
		begin
			r_d.wakeupStatus = WAKEUP_STATUS_FIELD_ENERGY;
		end

		case (nextState)
			ST_SLEEP_FRAME:
			begin
				r_d.powerMode = MODE_WAKE_FRAME;
			end
			ST_SLEEP_ENERGY:
			begin
				r_d.powerMode = MODE_ENERGY;
			end
			default:
			begin
				r_d.powerMode = MODE_NORMAL;
			end
		endcase

		r_d.ready = (nextState == ST_NORMAL);
		if (nextState == ST_RESUME && r_q.state != ST_RESUME)
		begin
			r_d.resumeCnt = RESUME_LOAD;
			r_d.writesArmed = 1'b0;
		end
		else if (r_q.resumeCnt != '0)
		begin
			r_d.resumeCnt = r_q.resumeCnt - 1'b1;
		end

		// Internal event is the status field qualified by its matching enable.
		eventActive = (r_d.wakeupStatus == WAKEUP_STATUS_FIELD_FRAME && r_d.wakeFrameEnable)
			|| (r_d.wakeupStatus == WAKEUP_STATUS_FIELD_ENERGY && r_d.energyDetectEnable);

		// Flag follows any event; a write of one clears it only after the event ends.
		if (eventActive)
		begin
			r_d.pmeIntStatus = 1'b1;
		end
		else if (intStatusClearWrite && r_q.writesArmed)
		begin
			r_d.pmeIntStatus = 1'b0;
		end

		eventQual = eventActive && r_d.eventPinEnable;
		r_d.eventQualPrev = eventQual;
		if (eventQual && !r_q.eventQualPrev)
		begin
			r_d.pulseCnt = PULSE_LOAD;
		end
		else if (r_q.pulseCnt != '0)
		begin
			r_d.pulseCnt = r_q.pulseCnt - 1'b1;
		end
		if (!eventQual)
		begin
			r_d.pulseCnt = '0;
		end
		r_d.eventPin = eventQual && (!r_d.eventPinPulseMode || r_d.pulseCnt != '0);

		r_d.frameDetectOn = (nextState == ST_SLEEP_FRAME);
		r_d.macHostClkEn = (nextState == ST_NORMAL) || (nextState == ST_RESUME);
		r_d.internalClkEn = (nextState != ST_SLEEP_ENERGY);
		r_d.rxPmClkEn = (nextState != ST_SLEEP_ENERGY);
		r_d.phyFullOn = (nextState != ST_SLEEP_ENERGY);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			r_q <= '0;
			r_q.state <= ST_NORMAL;
			r_q.ready <= RESET_READY;
			r_q.writesArmed <= RESET_ARMED;
			r_q.powerMode <= MODE_NORMAL;
			r_q.wakeupStatus <= WAKEUP_STATUS_FIELD_NONE;
			r_q.wakeFrameEnable <= RESET_ENABLE;
			r_q.energyDetectEnable <= RESET_ENABLE;
			r_q.eventPinEnable <= RESET_ENABLE;
			r_q.eventPinPulseMode <= RESET_ENABLE;
			r_q.macHostClkEn <= 1'b1;
			r_q.internalClkEn <= 1'b1;
			r_q.rxPmClkEn <= 1'b1;
			r_q.phyFullOn <= 1'b1;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign ready = r_q.ready;
	assign writesArmed = r_q.writesArmed;
	assign powerMode = r_q.powerMode;
	assign wakeupStatus = r_q.wakeupStatus;
	assign wakeFrameEnable = r_q.wakeFrameEnable;
	assign energyDetectEnable = r_q.energyDetectEnable;
	assign eventPinEnable = r_q.eventPinEnable;
	assign eventPinPulseMode = r_q.eventPinPulseMode;
	assign pmeIntStatus = r_q.pmeIntStatus;
	assign eventPin = r_q.eventPin;
	assign frameDetectOn = r_q.frameDetectOn;
	assign macHostClkEn = r_q.macHostClkEn;
	assign internalClkEn = r_q.internalClkEn;
	assign rxPmClkEn = r_q.rxPmClkEn;
	assign phyFullOn = r_q.phyFullOn;
endmodule : pswc_power_state_wake_ctrl

`default_nettype wire

// ### bench/pswc_chk.sv
// Purpose: Port-level assertions for the power state and wake controller.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound into the design after the module.
`timescale 1ns/1ps
`default_nettype none
module pswc_chk #(
	parameter int unsigned RESUME_CYCLES = 8,
	parameter int unsigned EVENT_PULSE_CYCLES = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ctrlWrite,
	input wire logic [1:0] ctrlWrPowerMode,
	input wire logic testRegWrite,
	input wire logic wakeFrameDetected,
	input wire logic carrierPresent,
	input wire logic intStatusClearWrite,
	input wire logic ready,
	input wire logic writesArmed,
	input wire logic [1:0] powerMode,
	input wire logic [1:0] wakeupStatus,
	input wire logic wakeFrameEnable,
	input wire logic eventPinPulseMode,
	input wire logic pmeIntStatus,
	input wire logic eventPin
);
	int unsigned resCnt;
	int unsigned pinCnt;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Length of the current resume and of the current event pin assertion.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			resCnt <= 0;
		else
			resCnt <= (ready || powerMode != 2'h0) ? 0 : resCnt + 1;
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pinCnt <= 0;
		else
			pinCnt <= (!eventPin) ? 0 : pinCnt + 1;
	end
	a_frame_entry: assert property (ctrlWrite && writesArmed && ready
		&& ctrlWrPowerMode == 2'h1 |-> ##2 !ready && powerMode == 2'h1) else $error("no frame sleep");
	a_energy_entry: assert property (ctrlWrite && writesArmed && ready
		&& ctrlWrPowerMode == 2'h2 |-> ##2 !ready && powerMode == 2'h2) else $error("no energy sleep");
	a_wake_mode: assert property (testRegWrite && powerMode != 2'h0 |=> powerMode == 2'h0
		&& !writesArmed) else $error("wake write ignored");
	a_resume_bound: assert property (resCnt <= RESUME_CYCLES) else $error("ready late");
	a_frame_status: assert property (wakeFrameDetected && powerMode == 2'h1 && wakeFrameEnable |=>
		wakeupStatus == 2'h2 && pmeIntStatus) else $error("frame event lost");
	a_carrier_status: assert property (carrierPresent && powerMode == 2'h2 |->
		##[1:2] wakeupStatus == 2'h1) else $error("carrier event lost");
	a_pulse_len: assert property (eventPinPulseMode |-> pinCnt <= EVENT_PULSE_CYCLES)
		else $error("event pulse too long");
	a_int_clear: assert property ($fell(pmeIntStatus) |-> $past(intStatusClearWrite))
		else $error("interrupt flag dropped");
	c_pulse: cover property (eventPin && eventPinPulseMode);
	c_wake: cover property ($rose(ready));
	c_carrier: cover property (wakeupStatus == 2'h1);
endmodule : pswc_chk
bind pswc_power_state_wake_ctrl pswc_chk #(.RESUME_CYCLES(RESUME_CYCLES),
	.EVENT_PULSE_CYCLES(EVENT_PULSE_CYCLES)) pswc_chk_inst (.*);
`default_nettype wire

// ### bench/pswc_host.sv
// Purpose: Host model making control, interrupt clear and wake accesses.
// Assumes: Strobes last one cycle and change just after a rising edge.
// Notes: cfg is pulse mode, pin enable, energy enable, frame enable, high to low.
`timescale 1ns/1ps
`default_nettype none
module pswc_host (
	input wire logic clk,
	input wire logic ready,
	output logic hostRead,
	output logic ctrlWrite,
	output logic [1:0] ctrlWrPowerMode,
	output logic [3:0] cfg,
	output logic [1:0] ctrlWrWakeupStatusClear,
	output logic intStatusClearWrite,
	output logic testRegWrite
);
	initial
		{hostRead, ctrlWrite, ctrlWrPowerMode, cfg, ctrlWrWakeupStatusClear,
			intStatusClearWrite, testRegWrite} = '0;
	// A write with no read before it, which the block must refuse.
	task automatic wrBare(input logic [1:0] m);
		@(posedge clk);
		ctrlWrite <= 1'b1;
		ctrlWrPowerMode <= m;
		@(posedge clk);
		ctrlWrite <= 1'b0;
	endtask : wrBare
	// A read always goes first, else the write would be dropped.
	task automatic wr(input logic [1:0] m, input logic [3:0] c, input logic [1:0] s, input logic i);
		@(posedge clk);
		hostRead <= 1'b1;
		@(posedge clk);
		hostRead <= 1'b0;
		ctrlWrite <= !i;
		intStatusClearWrite <= i;
		ctrlWrPowerMode <= m;
		cfg <= c;
		ctrlWrWakeupStatusClear <= s;
		@(posedge clk);
		ctrlWrite <= 1'b0;
		intStatusClearWrite <= 1'b0;
		ctrlWrWakeupStatusClear <= 2'h0;
	endtask : wr
	// Only the wake write is made, then ready is polled with a bound.
	task automatic wake(output logic ok);
		@(posedge clk);
		testRegWrite <= 1'b1;
		@(posedge clk);
		testRegWrite <= 1'b0;
		for (int i = 0; i < 40 && ready !== 1'b1; i++)
			@(negedge clk);
		ok = ready;
	endtask : wake
endmodule : pswc_host
`default_nettype wire

// ### bench/pswc_power_state_wake_ctrl_tb.sv
// Purpose: Self-checking bench for the power state and wake controller.
// Assumes: Resume and pulse counts shortened to 8 and 16 cycles.
// Notes: Frame detection and carrier come from here; the host model makes accesses.
`timescale 1ns/1ps
`default_nettype none
module pswc_power_state_wake_ctrl_tb;
	logic clk, reset, hostRead, ctrlWrite, intStatusClearWrite, testRegWrite, ready, eventPin;
	logic ctrlWrWakeFrameEnable, ctrlWrEnergyDetectEnable, ctrlWrEventPinEnable, wakeFrameEnable;
	logic ctrlWrEventPinPulseMode, wakeFrameDetected, carrierPresent, writesArmed, pmeIntStatus;
	logic energyDetectEnable, eventPinEnable, eventPinPulseMode, frameDetectOn, macHostClkEn;
	logic internalClkEn, rxPmClkEn, phyFullOn, ok;
	logic [1:0] ctrlWrPowerMode, ctrlWrWakeupStatusClear, powerMode, wakeupStatus;
	logic [3:0] cfg;
	int nFail = 0;
	int checks = 0;
	assign {ctrlWrEventPinPulseMode, ctrlWrEventPinEnable, ctrlWrEnergyDetectEnable,
		ctrlWrWakeFrameEnable} = cfg;
	pswc_power_state_wake_ctrl #(.RESUME_CYCLES(8), .EVENT_PULSE_CYCLES(16))
		pswc_power_state_wake_ctrl_inst (.*);
	pswc_host pswc_host_inst (.*);
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
		checks++;
		if (seen !== exp)
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		nFail += (seen !== exp);
	endtask : check
	task automatic print_verdict();
		if (nFail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic doWake();
		pswc_host_inst.wake(ok);
		check("ready", ok, 1'b1);
		if (ok !== 1'b1)
			print_verdict();
		check("powerMode", powerMode, 2'h0);
		check("writesArmed", writesArmed, 1'b0);
	endtask : doWake
	task automatic frameSleep();
		pswc_host_inst.wr(2'h0, 4'hd, 2'h0, 1'b0);
		pswc_host_inst.wr(2'h1, 4'hd, 2'h0, 1'b0);
		repeat (2) @(negedge clk);
		check("ready", ready, 1'b0);
		check("powerMode", powerMode, 2'h1);
		check("frameDetectOn", frameDetectOn, 1'b1);
		check("macHostClkEn", macHostClkEn, 1'b0);
		check("rxPmClkEn", rxPmClkEn, 1'b1);
		check("internalClkEn", internalClkEn, 1'b1);
		check("phyFullOn", phyFullOn, 1'b1);
		@(posedge clk);
		wakeFrameDetected <= 1'b1;
		@(posedge clk);
		wakeFrameDetected <= 1'b0;
		@(negedge clk);
		check("wakeupStatus", wakeupStatus, 2'h2);
		check("eventPin", eventPin, 1'b1);
		check("pmeIntStatus", pmeIntStatus, 1'b1);
		repeat (18) @(negedge clk);
		check("eventPin", eventPin, 1'b0);
		doWake();
		check("wakeFrameEnable", wakeFrameEnable, 1'b1);
		check("eventPinPulseMode", eventPinPulseMode, 1'b1);
		check("eventPinEnable", eventPinEnable, 1'b1);
		check("wakeupStatus", wakeupStatus, 2'h2);
		pswc_host_inst.wr(2'h0, 4'hd, 2'h2, 1'b0);
		pswc_host_inst.wr(2'h0, 4'hd, 2'h0, 1'b1);
		@(negedge clk);
		check("wakeupStatus", wakeupStatus, 2'h0);
		check("pmeIntStatus", pmeIntStatus, 1'b0);
	endtask : frameSleep
	task automatic energySleep();
		@(posedge clk);
		carrierPresent <= 1'b1;
		pswc_host_inst.wr(2'h2, 4'h6, 2'h0, 1'b0);
		repeat (3) @(negedge clk);
		check("internalClkEn", internalClkEn, 1'b0);
		check("rxPmClkEn", rxPmClkEn, 1'b0);
		check("phyFullOn", phyFullOn, 1'b0);
		check("powerMode", powerMode, 2'h2);
		check("wakeupStatus", wakeupStatus, 2'h1);
		repeat (20) @(negedge clk);
		check("eventPin", eventPin, 1'b1);
		doWake();
		check("energyDetectEnable", energyDetectEnable, 1'b1);
		pswc_host_inst.wr(2'h0, 4'h2, 2'h0, 1'b0);
		pswc_host_inst.wr(2'h0, 4'h2, 2'h0, 1'b1);
		@(negedge clk);
		check("eventPinEnable", eventPinEnable, 1'b0);
		check("eventPin", eventPin, 1'b0);
		check("pmeIntStatus", pmeIntStatus, 1'b1);
		pswc_host_inst.wr(2'h0, 4'h2, 2'h1, 1'b0);
		pswc_host_inst.wr(2'h0, 4'h2, 2'h0, 1'b1);
		@(negedge clk);
		check("pmeIntStatus", pmeIntStatus, 1'b0);
	endtask : energySleep
	initial
	begin
		reset = 1'b1;
		wakeFrameDetected = 1'b0;
		carrierPresent = 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check("ready", ready, 1'b1);
		check("writesArmed", writesArmed, 1'b0);
		pswc_host_inst.wrBare(2'h1);
		@(negedge clk);
		check("ready", ready, 1'b1);
		check("powerMode", powerMode, 2'h0);
		frameSleep();
		energySleep();
		pswc_host_inst.wake(ok);
		repeat (2) @(negedge clk);
		check("ready", ready, 1'b1);
		check("powerMode", powerMode, 2'h0);
		pswc_host_inst.wr(2'h3, 4'h0, 2'h0, 1'b0);
		repeat (2) @(negedge clk);
		check("ready", ready, 1'b1);
		check("powerMode", powerMode, 2'h0);
		print_verdict();
	end
endmodule : pswc_power_state_wake_ctrl_tb
`default_nettype wire
